// ---- pbb_pkg.sv ----
// Shared constants, layouts and carriers of the peripheral bus bridge
package pbb_pkg;

	// ****************************************************************
	// Address layout of the peripheral block
	// ****************************************************************
	localparam int unsigned ADDR_W = 32;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned HALF_W = 16;
	localparam int unsigned OFS_W = 16;
	localparam int unsigned WIN_W = 7;
	localparam int unsigned WIN_COUNT = 128;
	localparam int unsigned BLOCK_MSB = 31;
	localparam int unsigned BLOCK_LSB = 28;
	localparam int unsigned GAP_MSB = 27;
	localparam int unsigned GAP_LSB = 23;
	localparam int unsigned WIN_MSB = 22;
	localparam int unsigned WIN_LSB = 16;
	localparam int unsigned PORT_MSB = 6;
	localparam int unsigned PORT_LSB = 4;
	localparam logic [3:0] PERIPH_BLOCK = 4'h8;
	localparam logic [4:0] GAP_ZERO = 5'h0;
	localparam logic [WIN_W-1:0] CFG_WIN = 7'h00;

	// One bit per 64KB window: populated windows, and those 32 bits wide
	localparam logic [WIN_COUNT-1:0] MAP_MASK =
		128'h0000_0006_0001_000B_0007_07FF_1DFF_02DF;
	localparam logic [WIN_COUNT-1:0] WIDE_MASK =
		128'h0000_0006_0000_0008_0000_0725_0080_024E;

	// ****************************************************************
	// Configuration registers and timing control
	// ****************************************************************
	localparam logic [OFS_W-1:0] OFS_SILICON_REV = 16'h0000;
	localparam logic [OFS_W-1:0] OFS_FIRMWARE_REV = 16'h0004;
	localparam logic [OFS_W-1:0] OFS_CHIP_ID = 16'h0008;
	localparam logic [OFS_W-1:0] OFS_BUS_TIMING = 16'h0404;
	localparam int unsigned PORT_SLOTS = 8;
	localparam int unsigned WRITE_SEL_LSB = 8;
	localparam logic [2:0] VARIABLE_PORT = 3'h5;
	localparam logic [HALF_W-1:0] TIMING_RESET = 16'h007F;
	localparam logic [HALF_W-1:0] TIMING_MASK = 16'h7F7F;

	// ****************************************************************
	// Backbone bus encodings
	// ****************************************************************
	localparam int unsigned TRANS_ACTIVE_BIT = 1;
	localparam logic HRESP_OKAY = 1'b0;

	// Bridge sequencer states
	typedef enum logic [2:0] {
		PBB_IDLE = 3'b000,
		PBB_CFG = 3'b001,
		PBB_LATCH = 3'b010,
		PBB_SETUP = 3'b011,
		PBB_ACCESS = 3'b100
	} pbb_state_e;

	// Result of the central window decode
	typedef struct packed {
		logic mapped;
		logic wide;
		logic [2:0] port;
		logic [WIN_W-1:0] win;
	} pbb_decode_s;

	// One accepted backbone transfer
	typedef struct packed {
		logic [OFS_W-1:0] ofs;
		logic write;
		logic internal;
		pbb_decode_s dec;
	} pbb_xfer_s;

	// Offsets served by the bridge itself inside the configuration window
	function automatic logic pbb_cfg_hit(input logic [OFS_W-1:0] ofs);
		return (ofs == OFS_SILICON_REV) || (ofs == OFS_FIRMWARE_REV) ||
			(ofs == OFS_CHIP_ID) || (ofs == OFS_BUS_TIMING);
	endfunction

endpackage

// ---- pbb_decoder.sv ----
// Central address decoder of the peripheral block
`timescale 1ns/10ps
module pbb_decoder
	import pbb_pkg::*;
(
	// Incoming system address
	input wire logic [ADDR_W-1:0] haddr_i,
	// Window decode
	output pbb_decode_s dec_o
);

	// ****************************************************************
	// Window decode
	// ****************************************************************
	logic in_block;
	logic gap_clear;
	logic [WIN_W-1:0] win;

	// Only the peripheral block, and only windows below the gap bits
	assign in_block = (haddr_i[BLOCK_MSB:BLOCK_LSB] == PERIPH_BLOCK);
	assign gap_clear = (haddr_i[GAP_MSB:GAP_LSB] == GAP_ZERO);
	assign win = haddr_i[WIN_MSB:WIN_LSB];

	// Reserved windows fall out of the map mask and get no select
	assign dec_o.mapped = in_block & gap_clear & MAP_MASK[win];
	assign dec_o.wide = WIDE_MASK[win];
	assign dec_o.port = win[PORT_MSB:PORT_LSB];
	assign dec_o.win = win;

endmodule // pbb_decoder

// ---- pbb_config_regs.sv ----
// Identification, revision and bus timing registers of the bridge
`timescale 1ns/10ps
module pbb_config_regs
	import pbb_pkg::*;
#(
	parameter logic [3:0] EXT_FLAG = 4'h1,
	parameter logic [3:0] SILICON_MAJOR = 4'h0,
	parameter logic [7:0] SILICON_MINOR = 8'h00,
	parameter logic [3:0] FIRMWARE_MAJOR = 4'h0,
	parameter logic [7:0] FIRMWARE_MINOR = 8'h00,
	parameter logic [HALF_W-1:0] CHIP_ID = 16'h0A5C // arbitrary value
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic srst_i,
	// Read port, sampled at the address phase
	input wire logic rd_en_i,
	input wire logic [OFS_W-1:0] rd_ofs_i,
	// Write port, sampled at the data phase
	input wire logic wr_en_i,
	input wire logic [OFS_W-1:0] wr_ofs_i,
	input wire logic [HALF_W-1:0] wr_data_i,
	// Results
	output logic [HALF_W-1:0] rd_data_o,
	output logic [HALF_W-1:0] timing_o
);

	// ****************************************************************
	// Fixed values
	// ****************************************************************
	logic [HALF_W-1:0] silicon_revision;
	logic [HALF_W-1:0] firmware_revision;
	logic [HALF_W-1:0] chip_identifier;
	logic [HALF_W-1:0] rd_value;
	logic timing_we;

	// Flag, major, minor; revisions step by one per silicon or code spin
	assign silicon_revision = {EXT_FLAG, SILICON_MAJOR, SILICON_MINOR};
	assign firmware_revision = {EXT_FLAG, FIRMWARE_MAJOR, FIRMWARE_MINOR};
	// Identifier reads zero when the flag says it is absent
	assign chip_identifier = (EXT_FLAG != 4'h0) ? CHIP_ID : 16'h0000;

	// Read selection; unknown offsets read zero
	assign rd_value = (rd_ofs_i == OFS_SILICON_REV) ? silicon_revision :
		(rd_ofs_i == OFS_FIRMWARE_REV) ? firmware_revision :
		(rd_ofs_i == OFS_CHIP_ID) ? chip_identifier :
		(rd_ofs_i == OFS_BUS_TIMING) ? timing_o : 16'h0000;
	// Only the timing word takes writes; reserved bits stay zero
	assign timing_we = wr_en_i & (wr_ofs_i == OFS_BUS_TIMING) & pbb_cfg_hit(wr_ofs_i);

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			timing_o <= TIMING_RESET;
			rd_data_o <= 16'h0000;
		end else begin
			if (timing_we)
				timing_o <= wr_data_i & TIMING_MASK;
			if (rd_en_i)
				rd_data_o <= rd_value;
		end
	end

endmodule // pbb_config_regs

// ---- pbb_bridge.sv ----
// Backbone-to-peripheral bus bridge with central decoder and timing control
//
// What this block does
// - Backbone, peripheral bus and bridge all run on the core clock.
// - The bridge is the only master driving the peripheral bus.
// - Peripheral slaves live only in the peripheral block, forwarded here.
// - One central decoder makes one select per peripheral window.
// - Only the offset part of the address goes onto the peripheral bus.
// - Each slave gets at most 64KB: sixteen offset address lines.
// - Slaves are 16 or 32 bits wide, per the window map.
// - Configuration window is 16 bits wide at bottom; DMA window 32.
// - Silicon revision: read-only, flag nibble, major nibble, minor byte.
// - Revision fields step by one per metal fix or major step.
// - Nonzero flag means the chip identifier register holds a valid value.
// - Firmware revision: read-only, same three-field layout.
// - Chip identifier: read-only, four 4-bit code digits.
// - Read timing bit per port at its index; 1 adds a cycle; bits 0-6 reset 1, bit 7 stays 0.
// - Write timing bit per port at eight plus index; resets 0.
// - Port five holds each transfer until its slave acknowledges.
// - Timing control word is read-write at offset 0x404.
`timescale 1ns/10ps
module pbb_bridge
	import pbb_pkg::*;
#(
	parameter logic [3:0] EXT_FLAG = 4'h1,
	parameter logic [3:0] SILICON_MAJOR = 4'h0,
	parameter logic [7:0] SILICON_MINOR = 8'h00,
	parameter logic [3:0] FIRMWARE_MAJOR = 4'h0,
	parameter logic [7:0] FIRMWARE_MINOR = 8'h00,
	parameter logic [HALF_W-1:0] CHIP_ID = 16'h0A5C // arbitrary value
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic srst_i,

	// Backbone bus slave, address phase
	input wire logic hsel_i,
	input wire logic [ADDR_W-1:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic hready_i,

	// Backbone bus slave, data phase
	input wire logic [DATA_W-1:0] hwdata_i,
	output logic [DATA_W-1:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,

	// Peripheral bus master
	output logic [WIN_COUNT-1:0] psel_o,
	output logic [OFS_W-1:0] paddr_o,
	output logic penable_o,
	output logic pwrite_o,
	output logic [DATA_W-1:0] pwdata_o,
	input wire logic [DATA_W-1:0] prdata_i,
	input wire logic pready_i
);

	// ****************************************************************
	// State
	// ****************************************************************
	pbb_state_e state_reg;
	pbb_state_e state_next;
	pbb_xfer_s xfer_reg;
	pbb_xfer_s xfer_next;
	logic extra_reg;
	logic extra_next;
	logic [DATA_W-1:0] hrdata_reg;
	logic [DATA_W-1:0] hrdata_next;
	logic hreadyout_reg;
	logic hreadyout_next;
	logic hresp_reg;
	logic [WIN_COUNT-1:0] psel_reg;
	logic [WIN_COUNT-1:0] psel_next;
	logic [OFS_W-1:0] paddr_reg;
	logic [OFS_W-1:0] paddr_next;
	logic penable_reg;
	logic penable_next;
	logic pwrite_reg;
	logic pwrite_next;
	logic [DATA_W-1:0] pwdata_reg;
	logic [DATA_W-1:0] pwdata_next;

	// ****************************************************************
	// Decode and selection
	// ****************************************************************
	pbb_decode_s dec;
	logic accept;
	logic internal_now;
	logic cfg_rd_en;
	logic cfg_wr_en;
	logic [HALF_W-1:0] cfg_rdata;
	logic [HALF_W-1:0] timing;
	logic [PORT_SLOTS-1:0] read_slow;
	logic [PORT_SLOTS-1:0] write_slow;
	logic slow;
	logic variable;
	logic access_done;
	logic [WIN_COUNT-1:0] sel_onehot;
	logic [DATA_W-1:0] wdata_fmt;
	logic [DATA_W-1:0] rdata_fmt;

	// Central decoder of the peripheral windows
	pbb_decoder u_decoder (
		.haddr_i(haddr_i),
		.dec_o(dec)
	);

	// Identification and timing registers, served inside the bridge
	pbb_config_regs #(
		.EXT_FLAG(EXT_FLAG),
		.SILICON_MAJOR(SILICON_MAJOR),
		.SILICON_MINOR(SILICON_MINOR),
		.FIRMWARE_MAJOR(FIRMWARE_MAJOR),
		.FIRMWARE_MINOR(FIRMWARE_MINOR),
		.CHIP_ID(CHIP_ID)
	) u_config_regs (
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.rd_en_i(cfg_rd_en),
		.rd_ofs_i(haddr_i[OFS_W-1:0]),
		.wr_en_i(cfg_wr_en),
		.wr_ofs_i(xfer_reg.ofs),
		.wr_data_i(hwdata_i[HALF_W-1:0]),
		.rd_data_o(cfg_rdata),
		.timing_o(timing)
	);

	// A transfer is taken only while the bridge is idle
	assign accept = hsel_i & htrans_i[TRANS_ACTIVE_BIT] & hready_i &
		(state_reg == PBB_IDLE);
	// Bridge registers sit at their own offsets of the configuration window;
	// the rest of that window still goes out to the configuration slave
	assign internal_now = dec.mapped & (dec.win == CFG_WIN) &
		pbb_cfg_hit(haddr_i[OFS_W-1:0]);
	assign cfg_rd_en = accept & internal_now & ~hwrite_i;
	// Write data only exists in the data phase, one cycle after accept
	assign cfg_wr_en = (state_reg == PBB_CFG) & xfer_reg.write & xfer_reg.internal;

	// Per-port timing bits, chosen by direction
	assign read_slow = timing[PORT_SLOTS-1:0];
	assign write_slow = timing[WRITE_SEL_LSB +: PORT_SLOTS];
	assign slow = xfer_reg.write ? write_slow[xfer_reg.dec.port] :
		read_slow[xfer_reg.dec.port];
	assign variable = (xfer_reg.dec.port == VARIABLE_PORT);
	// Port five ignores its timing bits and waits on the acknowledge
	assign access_done = variable ? pready_i : ~extra_reg;

	// One select per window, from the latched window number
	assign sel_onehot = {{(WIN_COUNT-1){1'b0}}, 1'b1} << xfer_reg.dec.win;
	// Narrow slaves see and return only the low half-word
	assign wdata_fmt = xfer_reg.dec.wide ? hwdata_i :
		{{(DATA_W-HALF_W){1'b0}}, hwdata_i[HALF_W-1:0]};
	assign rdata_fmt = xfer_reg.dec.wide ? prdata_i :
		{{(DATA_W-HALF_W){1'b0}}, prdata_i[HALF_W-1:0]};

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	// Every access waits at least one cycle, so a read right after a
	// write to the timing word always sees the new value
	always_comb begin
		state_next = state_reg;
		xfer_next = xfer_reg;
		extra_next = extra_reg;
		hrdata_next = hrdata_reg;
		hreadyout_next = hreadyout_reg;
		psel_next = psel_reg;
		paddr_next = paddr_reg;
		penable_next = penable_reg;
		pwrite_next = pwrite_reg;
		pwdata_next = pwdata_reg;
		unique case (state_reg)
			PBB_IDLE: begin
				if (accept) begin
					xfer_next.ofs = haddr_i[OFS_W-1:0];
					xfer_next.write = hwrite_i;
					xfer_next.internal = internal_now;
					xfer_next.dec = dec;
					hreadyout_next = 1'b0;
					// Unmapped windows never reach the peripheral bus
					if (internal_now || !dec.mapped) begin
						state_next = PBB_CFG;
					end else begin
						state_next = PBB_LATCH;
					end
				end
			end
			PBB_CFG: begin
				// Reads of reserved space return zero
				hrdata_next = (xfer_reg.internal && !xfer_reg.write) ?
					{{(DATA_W-HALF_W){1'b0}}, cfg_rdata} : {DATA_W{1'b0}};
				hreadyout_next = 1'b1;
				state_next = PBB_IDLE;
			end
			PBB_LATCH: begin
				// Setup phase: select, offset only, direction and data
				psel_next = sel_onehot;
				paddr_next = xfer_reg.ofs;
				pwrite_next = xfer_reg.write;
				pwdata_next = xfer_reg.write ? wdata_fmt : {DATA_W{1'b0}};
				state_next = PBB_SETUP;
			end
			PBB_SETUP: begin
				penable_next = 1'b1;
				extra_next = slow;
				state_next = PBB_ACCESS;
			end
			PBB_ACCESS: begin
				if (access_done) begin
					psel_next = {WIN_COUNT{1'b0}};
					penable_next = 1'b0;
					hrdata_next = xfer_reg.write ? {DATA_W{1'b0}} : rdata_fmt;
					hreadyout_next = 1'b1;
					state_next = PBB_IDLE;
				end else if (!variable) begin
					extra_next = 1'b0;
				end
			end
			default: begin
				state_next = PBB_IDLE;
				hreadyout_next = 1'b1;
				psel_next = {WIN_COUNT{1'b0}};
				penable_next = 1'b0;
			end
		endcase
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	// Single clock for both buses; no crossing anywhere
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			state_reg <= PBB_IDLE;
			xfer_reg <= '0;
			extra_reg <= 1'b0;
			hrdata_reg <= {DATA_W{1'b0}};
			hreadyout_reg <= 1'b1;
			hresp_reg <= HRESP_OKAY;
		end else begin
			state_reg <= state_next;
			xfer_reg <= xfer_next;
			extra_reg <= extra_next;
			hrdata_reg <= hrdata_next;
			hreadyout_reg <= hreadyout_next;
			hresp_reg <= HRESP_OKAY;
		end
	end

	// Peripheral bus drive, only ever from this bridge
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			psel_reg <= {WIN_COUNT{1'b0}};
			paddr_reg <= {OFS_W{1'b0}};
			penable_reg <= 1'b0;
			pwrite_reg <= 1'b0;
			pwdata_reg <= {DATA_W{1'b0}};
		end else begin
			psel_reg <= psel_next;
			paddr_reg <= paddr_next;
			penable_reg <= penable_next;
			pwrite_reg <= pwrite_next;
			pwdata_reg <= pwdata_next;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign hrdata_o = hrdata_reg;
	assign hreadyout_o = hreadyout_reg;
	assign hresp_o = hresp_reg;
	assign psel_o = psel_reg;
	assign paddr_o = paddr_reg;
	assign penable_o = penable_reg;
	assign pwrite_o = pwrite_reg;
	assign pwdata_o = pwdata_reg;

endmodule // pbb_bridge

// ---- pbb_bridge_props.sv ----
// Checker of the bridge top-level port behaviour
`timescale 1ns/10ps
module pbb_bridge_props
	import pbb_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic srst_i,
	// Backbone side
	input wire logic hsel_i,
	input wire logic [ADDR_W-1:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hready_i,
	input wire logic [DATA_W-1:0] hrdata_o,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	// Peripheral side
	input wire logic [WIN_COUNT-1:0] psel_o,
	input wire logic [OFS_W-1:0] paddr_o,
	input wire logic penable_o,
	input wire logic pwrite_o,
	input wire logic [DATA_W-1:0] pwdata_o,
	input wire logic pready_i
);
	// ****************************************************************
	// Helpers
	// ****************************************************************
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	// Accepted request and port five activity
	wire take = hsel_i && htrans_i[1] && hready_i && hreadyout_o;
	wire var_port = |psel_o[95:80];

	// ****************************************************************
	// Properties
	// ****************************************************************
	property p_reset_idle;
		$fell(srst_i) |-> (psel_o == '0) && hreadyout_o && !penable_o && (hrdata_o == '0);
	endproperty
	property p_okay;
		hresp_o == HRESP_OKAY;
	endproperty
	property p_accept;
		take |=> !hreadyout_o;
	endproperty
	property p_cfg_turn;
		take && (haddr_i == 32'h8000_0404) |=> !hreadyout_o ##1 hreadyout_o;
	endproperty
	property p_onehot;
		$onehot0(psel_o);
	endproperty
	property p_mapped;
		(psel_o & ~MAP_MASK) == '0;
	endproperty
	property p_setup;
		$rose(|psel_o) |-> !penable_o ##1 penable_o;
	endproperty
	property p_stable;
		penable_o |-> $stable(psel_o) && $stable(paddr_o) && $stable(pwrite_o) && $stable(pwdata_o);
	endproperty
	property p_fixed_len;
		penable_o && !var_port |-> ##[1:2] !penable_o;
	endproperty
	property p_var_hold;
		penable_o && var_port && !pready_i |=> penable_o;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("reset values wrong");
	a_okay: assert property (p_okay) else $error("response not okay");
	a_accept: assert property (p_accept) else $error("no wait after accept");
	a_cfg_turn: assert property (p_cfg_turn) else $error("config turnaround");
	a_onehot: assert property (p_onehot) else $error("select not one-hot");
	a_mapped: assert property (p_mapped) else $error("reserved window selected");
	a_setup: assert property (p_setup) else $error("setup phase wrong");
	a_stable: assert property (p_stable) else $error("bus moved in access");
	a_fixed_len: assert property (p_fixed_len) else $error("access too long");
	a_var_hold: assert property (p_var_hold) else $error("port five released early");
	// Main scenarios seen; the config turn is covered on its real sequence
	c_cfg: cover property (take && (haddr_i == 32'h8000_0404) ##1 !hreadyout_o ##1 hreadyout_o);
	c_var: cover property (penable_o && var_port && !pready_i);
	c_wr: cover property (penable_o && pwrite_o);
endmodule // pbb_bridge_props

// ---- pbb_slave_model.sv ----
// Peripheral slave model on the far side of the bridge
`timescale 1ns/10ps
module pbb_slave_model
	import pbb_pkg::*;
(
	// Clock
	input wire logic core_clk_i,
	// Peripheral bus from the bridge
	input wire logic [WIN_COUNT-1:0] psel_i,
	input wire logic [OFS_W-1:0] paddr_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [DATA_W-1:0] pwdata_i,
	output logic [DATA_W-1:0] prdata_o,
	output logic pready_o,
	// Scenario control and observation
	input wire logic [3:0] stall_i,
	output logic [OFS_W-1:0] last_ofs_o
);
	logic [DATA_W-1:0] mem_reg = 32'h0;
	logic [3:0] wait_reg = 4'h0;
	wire sel = |psel_i;
	// Idle bus shows the inverse, so a sample taken too early is caught
	assign prdata_o = (sel && penable_i) ? mem_reg : ~mem_reg;
	// Acknowledge only after the commanded count of access cycles
	assign pready_o = penable_i && (wait_reg >= stall_i);
	// One shared word of storage; offset kept for the bench
	always_ff @(posedge core_clk_i) begin
		wait_reg <= penable_i ? wait_reg + 4'h1 : 4'h0;
		if (sel) last_ofs_o <= paddr_i;
		if (sel && penable_i && pwrite_i) mem_reg <= pwdata_i;
	end
endmodule // pbb_slave_model

// ---- tb_peripheral_bus_bridge_config.sv ----
// Self-checking testbench of the peripheral bus bridge
`timescale 1ns/10ps
module tb_peripheral_bus_bridge_config;
	import pbb_pkg::*;
	// Row: address, write, data, expected read or bus write data, cycles, stall
	typedef struct packed {
		logic [31:0] a;
		logic w;
		logic [31:0] d;
		logic [31:0] e;
		logic [3:0] c;
		logic [3:0] s;
	} pbb_row_s;
	// ****************************************************************
	// Signals and instances
	// ****************************************************************
	logic core_clk_i = 0;
	logic srst_i = 1;
	logic hsel_i = 0;
	logic hwrite_i = 0;
	logic [1:0] htrans_i = 2'b00;
	logic [31:0] haddr_i = 32'h0;
	logic [31:0] hwdata_i = 32'h0;
	logic [3:0] stall = 4'h0;
	wire [31:0] hrdata_o, pwdata_o, prdata_i;
	wire hreadyout_o, hresp_o, penable_o, pwrite_o, pready_i;
	wire [WIN_COUNT-1:0] psel_o;
	wire [15:0] paddr_o, ofs;
	wire hready_i = hreadyout_o;
	int error_cnt = 0;
	int checks_done = 0;
	// Select and write data seen on the peripheral bus in the access cycle
	logic [WIN_COUNT-1:0] sel_seen;
	logic [31:0] wd_seen;
	always @(posedge core_clk_i) begin
		if (penable_o) sel_seen <= psel_o;
		if (penable_o && pwrite_o) wd_seen <= pwdata_o;
	end
	pbb_bridge #(.CHIP_ID(16'h0A5C)) uut (.core_clk_i(core_clk_i), .srst_i(srst_i),
		.hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
		.hready_i(hready_i), .hwdata_i(hwdata_i), .hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .psel_o(psel_o), .paddr_o(paddr_o),
		.penable_o(penable_o), .pwrite_o(pwrite_o), .pwdata_o(pwdata_o),
		.prdata_i(prdata_i), .pready_i(pready_i));
	pbb_slave_model u_slave (.core_clk_i(core_clk_i), .psel_i(psel_o), .paddr_i(paddr_o),
		.penable_i(penable_o), .pwrite_i(pwrite_o), .pwdata_i(pwdata_o),
		.prdata_o(prdata_i), .pready_o(pready_i), .stall_i(stall), .last_ofs_o(ofs));
	// Chip code 0A5C is arbitrary; revisions default to flag 1, zero fields
	pbb_row_s rows [22] = '{
		'{32'h8000_0000, 1'b0, 32'h0, 32'h0000_1000, 4'h2, 4'h0},
		'{32'h8000_0004, 1'b0, 32'h0, 32'h0000_1000, 4'h2, 4'h0},
		'{32'h8000_0008, 1'b0, 32'h0, 32'h0000_0A5C, 4'h2, 4'h0},
		'{32'h8000_0404, 1'b0, 32'h0, 32'h0000_007F, 4'h2, 4'h0},
		'{32'h8000_0000, 1'b1, 32'hFFFF_FFFF, 32'h0, 4'h2, 4'h0},
		'{32'h8000_0000, 1'b0, 32'h0, 32'h0000_1000, 4'h2, 4'h0},
		'{32'h8001_0ABC, 1'b1, 32'h1234_5678, 32'h1234_5678, 4'h4, 4'h0},
		'{32'h8001_0ABC, 1'b0, 32'h0, 32'h1234_5678, 4'h5, 4'h0},
		'{32'h8010_0123, 1'b1, 32'hDEAD_BEEF, 32'h0000_BEEF, 4'h4, 4'h0},
		'{32'h8010_0123, 1'b0, 32'h0, 32'h0000_BEEF, 4'h5, 4'h0},
		'{32'h8000_0404, 1'b1, 32'hFFFF_FFFF, 32'h0, 4'h2, 4'h0},
		'{32'h8000_0404, 1'b0, 32'h0, 32'h0000_7F7F, 4'h2, 4'h0},
		'{32'h8062_0010, 1'b1, 32'hCAFE_F00D, 32'hCAFE_F00D, 4'h5, 4'h0},
		'{32'h8062_0010, 1'b0, 32'h0, 32'hCAFE_F00D, 4'h5, 4'h0},
		'{32'h8000_0404, 1'b1, 32'h0, 32'h0, 4'h2, 4'h0},
		'{32'h8043_0004, 1'b0, 32'h0, 32'hCAFE_F00D, 4'h4, 4'h0},
		'{32'h8000_0010, 1'b0, 32'h0, 32'h0000_F00D, 4'h4, 4'h0},
		'{32'h8005_0000, 1'b0, 32'h0, 32'h0, 4'h2, 4'h0},
		'{32'h9000_0000, 1'b0, 32'h0, 32'h0, 4'h2, 4'h0},
		'{32'h8080_0000, 1'b0, 32'h0, 32'h0, 4'h2, 4'h0},
		'{32'h8050_0020, 1'b1, 32'h0000_5A5A, 32'h0000_5A5A, 4'h4, 4'h0},
		'{32'h8050_0020, 1'b0, 32'h0, 32'h0000_5A5A, 4'h7, 4'h3}};
	// ****************************************************************
	// Tasks
	// ****************************************************************
	always #10 core_clk_i = ~core_clk_i;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	// Entered just after an edge, so requests run back to back
	task automatic xfer(input pbb_row_s r, output logic [31:0] rd, output int n);
		hsel_i = 1;
		htrans_i = 2'b10;
		haddr_i = r.a;
		hwrite_i = r.w;
		stall = r.s;
		@(posedge core_clk_i);
		#1;
		hsel_i = 0;
		htrans_i = 2'b00;
		hwdata_i = r.d;
		n = 1;
		while (hreadyout_o !== 1'b1 && n < 40) begin
			@(posedge core_clk_i);
			#1;
			n++;
		end
		rd = hrdata_o;
	endtask
	task automatic rst_chk();
		chk({paddr_o, 13'h0, hreadyout_o, penable_o, pwrite_o}, 32'h0000_0004, "idle");
		chk({31'h0, |psel_o}, 32'h0, "select idle");
		chk(pwdata_o | hrdata_o | {31'h0, hresp_o}, 32'h0, "reset data");
	endtask
	task automatic final_report();
		$display("Checks %0d, errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// ****************************************************************
	// Sequence
	// ****************************************************************
	initial begin
		#200000;
		error_cnt++;
		final_report();
	end
	initial begin
		logic [31:0] rd;
		int n;
		repeat (10) @(posedge core_clk_i);
		#1;
		rst_chk();
		srst_i = 0;
		for (int i = 0; i < 22; i++) begin
			xfer(rows[i], rd, n);
			chk(n, rows[i].c, "cycles");
			if (!rows[i].w) chk(rd, rows[i].e, "read");
			if (rows[i].c > 2) chk(ofs, rows[i].a[15:0], "offset");
			if (rows[i].c > 2) chk({31'h0, sel_seen[rows[i].a[22:16]] && $onehot(sel_seen)}, 32'h1, "select");
			if (rows[i].w && rows[i].c > 2) chk(wd_seen, rows[i].e, "bus write data");
			$display("Row %0d done", i);
		end
		// Reset in mid-run restores the timing word
		srst_i = 1;
		repeat (2) @(posedge core_clk_i);
		#1;
		rst_chk();
		srst_i = 0;
		xfer(rows[3], rd, n);
		chk(rd, 32'h0000_007F, "timing after reset");
		$display("Reset test done");
		final_report();
	end
endmodule // tb_peripheral_bus_bridge_config
bind pbb_bridge pbb_bridge_props u_props (.core_clk_i(core_clk_i), .srst_i(srst_i),
	.hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hready_i(hready_i),
	.hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .psel_o(psel_o),
	.paddr_o(paddr_o), .penable_o(penable_o), .pwrite_o(pwrite_o), .pwdata_o(pwdata_o),
	.pready_i(pready_i));
